/* File: design/page_auth_pkg.sv */
// shared constants for the page authentication signature command
package page_auth_pkg;

  // ****************************************
  // frame bytes and result codes
  // ****************************************
  localparam logic [7:0] CMD_START      = 8'h66;
  localparam logic [7:0] CMD_CODE       = 8'ha5;
  localparam logic [7:0] REQ_LEN        = 8'h22;
  localparam logic [7:0] RESP_LEN_FULL  = 8'h41;
  localparam logic [7:0] RESP_LEN_SHORT = 8'h01;
  localparam logic [7:0] DUMMY_BYTE     = 8'hff;
  localparam logic [7:0] HIDDEN_ID_BYTE = 8'hff;
  localparam logic [7:0] RES_OK         = 8'haa;
  localparam logic [7:0] RES_FAIL       = 8'h22;
  localparam logic [7:0] RES_INVALID    = 8'h77;
  localparam logic [7:0] RES_DISABLED   = 8'h88;

  // ****************************************
  // parameter byte fields
  // ****************************************
  localparam int         IDSEL_MSB = 7;
  localparam int         IDSEL_LSB = 5;
  localparam int         PAGE_MSB  = 2;
  localparam int         PAGE_LSB  = 0;
  localparam logic [2:0] IDSEL_ROM = 3'h0;
  localparam logic [2:0] IDSEL_FF  = 3'h7;
  localparam logic [2:0] LAST_PAGE = 3'h6;

  // ****************************************
  // hash input layout and response layout
  // ****************************************
  localparam logic [6:0] H_PAGE0  = 7'h08;
  localparam logic [6:0] H_CHAL0  = 7'h28;
  localparam logic [6:0] H_PGNUM  = 7'h48;
  localparam logic [6:0] H_MAKER0 = 7'h49;
  localparam logic [6:0] H_LAST   = 7'h4a;
  localparam logic [5:0] CHAL_LAST = 6'h1f;
  localparam logic [6:0] R_LEN    = 7'h01;
  localparam logic [6:0] R_RES    = 7'h02;
  localparam logic [6:0] R_SIG0   = 7'h03;
  localparam logic [6:0] R_CRC_FULL  = 7'h43;
  localparam logic [6:0] R_CRC_SHORT = 7'h03;

  // ****************************************
  // crc and timing
  // ****************************************
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam int SIG_TIME_US     = 100;
  localparam int CLK_FREQ_MHZ    = 125;
  localparam int SIG_TIME_CYCLES = SIG_TIME_US * CLK_FREQ_MHZ;

endpackage

/* File: design/crc16_byte.sv */
// byte-serial crc-16, reflected form, one byte per cycle
`timescale 1ns/1ps
`default_nettype none
module crc16_byte (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // byte feed
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // running value
  output logic      [15:0] crc
);
  import page_auth_pkg::*;

  logic [15:0] nxt_crc;

  always_comb begin
    nxt_crc = (clr ? CRC_INIT : crc) ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      nxt_crc = nxt_crc[0] ? ((nxt_crc >> 1) ^ CRC_POLY) : (nxt_crc >> 1);
    end
  end

  // clear and feed in one cycle seeds the first byte
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= nxt_crc;
    end else if (clr) begin
      crc <= CRC_INIT;
    end
  end
endmodule
`default_nettype wire

/* File: design/tx_buffer2.sv */
// two-entry buffer with registered head, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tx_buffer2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] d1_ff;
  logic             v1_ff;
  logic             pop;
  logic             push;

  // ready only from a flop, so the source sees no combinational path
  assign in_ready = ~v1_ff;
  assign pop      = out_valid & out_ready;
  assign push     = in_valid & ~v1_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_data  <= '0;
      out_valid <= 1'b0;
      d1_ff     <= '0;
      v1_ff     <= 1'b0;
    end else if (pop) begin
      if (v1_ff) begin
        out_data <= d1_ff;
        v1_ff    <= 1'b0;
      end else begin
        out_data  <= in_data;
        out_valid <= push;
      end
    end else if (push) begin
      if (!out_valid) begin
        out_data  <= in_data;
        out_valid <= 1'b1;
      end else begin
        d1_ff <= in_data;
        v1_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/page_auth_sign.sv */
// page authentication signature command: frame parse, hash feed, signer control, response
`timescale 1ns/1ps
`default_nettype none
module page_auth_sign
  import page_auth_pkg::*;
#(
  parameter int SIG_TIMEOUT_CYCLES = page_auth_pkg::SIG_TIME_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // link byte layer
  input  wire logic        link_reset,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  // identity and configuration
  input  wire logic [63:0] unique_rom_identifier,
  input  wire logic [15:0] maker_id_bytes,
  input  wire logic        device_disabled,
  // page memory read
  output logic             page_rd_en,
  output logic [2:0]       page_rd_page,
  output logic [4:0]       page_rd_byte,
  input  wire logic        page_rd_valid,
  input  wire logic [7:0]  page_rd_data,
  // hash input stream
  output logic             hash_valid,
  output logic [7:0]       hash_byte,
  output logic             hash_last,
  input  wire logic        hash_ready,
  // signer
  output logic             sign_start,
  output logic             unclonable_key_source_en,
  input  wire logic        sig_byte_valid,
  input  wire logic [7:0]  sig_byte,
  input  wire logic        sign_done,
  input  wire logic        sign_fail,
  // status
  output logic             busy,
  output logic [7:0]       result_code
);
  import page_auth_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_LEN, S_CMD, S_PARAM, S_CHAL, S_REQ_CRC, S_RELEASE,
    S_HASH_FETCH, S_HASH_WAIT, S_HASH_PUT, S_SIGN, S_RESP
  } state_t;

  // ****************************************
  // state
  // ****************************************
  state_t      state_ff;
  logic [7:0]  param_ff;
  logic [7:0]  chal_mem [0:31];
  logic [7:0]  sig_mem  [0:63];
  logic [5:0]  chal_idx_ff;
  logic [5:0]  sig_wr_idx_ff;
  logic [6:0]  hash_idx_ff;
  logic [6:0]  resp_idx_ff;
  logic        resp_short_ff;
  logic [7:0]  result_ff;
  logic        fail_sticky_ff;
  logic [31:0] sign_cnt_ff;
  logic        req_crc_idx_ff;
  logic        page_rd_en_ff;
  logic [2:0]  page_rd_page_ff;
  logic [4:0]  page_rd_byte_ff;
  logic        hash_valid_ff;
  logic [7:0]  hash_byte_ff;
  logic        hash_last_ff;
  logic        sign_start_ff;
  logic        key_en_ff;
  logic        busy_ff;

  logic        push_valid;
  logic [7:0]  push_data;
  logic        push_ready;
  logic        push_fire;
  logic        crc_clr;
  logic        crc_en;
  logic [7:0]  crc_data;
  logic [15:0] crc_q;
  logic        param_ok;
  logic        sign_timeout;
  logic [6:0]  crc_at;
  logic [5:0]  sig_rd_idx;
  logic [6:0]  chal_off;
  logic [6:0]  page_off;

  assign param_ok = ((param_ff[IDSEL_MSB:IDSEL_LSB] == IDSEL_ROM) ||
                     (param_ff[IDSEL_MSB:IDSEL_LSB] == IDSEL_FF)) &&
                    (param_ff[PAGE_MSB:PAGE_LSB] <= LAST_PAGE);
  assign sign_timeout = (sign_cnt_ff == 32'(SIG_TIMEOUT_CYCLES - 1));
  assign crc_at     = resp_short_ff ? R_CRC_SHORT : R_CRC_FULL;
  assign sig_rd_idx = 6'(resp_idx_ff - R_SIG0);
  assign chal_off   = hash_idx_ff - H_CHAL0;
  assign page_off   = hash_idx_ff - H_PAGE0;
  assign push_fire  = push_valid & push_ready;

  // ****************************************
  // transmit byte selection
  // ****************************************
  always_comb begin
    push_valid = 1'b0;
    push_data  = 8'h00;
    if (state_ff == S_REQ_CRC) begin
      push_valid = 1'b1;
      push_data  = req_crc_idx_ff ? ~crc_q[15:8] : ~crc_q[7:0];
    end else if (state_ff == S_RESP) begin
      push_valid = 1'b1;
      if (resp_idx_ff == 7'h00) begin
        push_data = DUMMY_BYTE;
      end else if (resp_idx_ff == R_LEN) begin
        push_data = resp_short_ff ? RESP_LEN_SHORT : RESP_LEN_FULL;
      end else if (resp_idx_ff == R_RES) begin
        push_data = result_ff;
      end else if (resp_idx_ff == crc_at) begin
        push_data = ~crc_q[7:0];
      end else if (resp_idx_ff == crc_at + 7'h01) begin
        push_data = ~crc_q[15:8];
      end else begin
        push_data = (result_ff == RES_OK) ? sig_mem[sig_rd_idx] : 8'h00;
      end
    end
  end

  // ****************************************
  // crc feed: request bytes, then response bytes after the dummy
  // ****************************************
  always_comb begin
    crc_clr  = 1'b0;
    crc_en   = 1'b0;
    crc_data = rx_data;
    if (state_ff == S_IDLE) begin
      crc_clr = 1'b1;
      crc_en  = rx_valid && (rx_data == CMD_START);
    end else if (state_ff inside {S_LEN, S_CMD, S_PARAM, S_CHAL}) begin
      crc_en = rx_valid;
    end else if (state_ff == S_RESP) begin
      crc_data = push_data;
      crc_clr  = (resp_idx_ff == 7'h00);
      crc_en   = push_fire && (resp_idx_ff != 7'h00) && (resp_idx_ff < crc_at);
    end
  end

  crc16_byte u_crc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clr     (crc_clr),
    .en      (crc_en),
    .data    (crc_data),
    .crc     (crc_q)
  );

  tx_buffer2 #(.WIDTH(8)) u_txbuf (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (push_valid),
    .in_data   (push_data),
    .in_ready  (push_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff       <= S_IDLE;
      param_ff       <= 8'h00;
      chal_idx_ff    <= 6'h00;
      hash_idx_ff    <= 7'h00;
      resp_idx_ff    <= 7'h00;
      resp_short_ff  <= 1'b0;
      result_ff      <= 8'h00;
      req_crc_idx_ff <= 1'b0;
      sign_cnt_ff    <= 32'h0;
      page_rd_en_ff  <= 1'b0;
      hash_valid_ff  <= 1'b0;
      hash_last_ff   <= 1'b0;
      sign_start_ff  <= 1'b0;
    end else begin
      page_rd_en_ff <= 1'b0;
      sign_start_ff <= 1'b0;
      if (link_reset) begin
        state_ff      <= S_IDLE;
        hash_valid_ff <= 1'b0;
        hash_last_ff  <= 1'b0;
      end else begin
        unique case (state_ff)
          S_IDLE: if (rx_valid && rx_data == CMD_START) state_ff <= S_LEN;
          S_LEN: if (rx_valid) state_ff <= (rx_data == REQ_LEN) ? S_CMD : S_IDLE;
          S_CMD: if (rx_valid) state_ff <= (rx_data == CMD_CODE) ? S_PARAM : S_IDLE;
          S_PARAM: if (rx_valid) begin
            param_ff    <= rx_data;
            chal_idx_ff <= 6'h00;
            state_ff    <= S_CHAL;
          end
          S_CHAL: if (rx_valid) begin
            chal_idx_ff <= chal_idx_ff + 6'h01;
            if (chal_idx_ff == CHAL_LAST) begin
              req_crc_idx_ff <= 1'b0;
              state_ff       <= S_REQ_CRC;
            end
          end
          S_REQ_CRC: if (push_fire) begin
            req_crc_idx_ff <= 1'b1;
            if (req_crc_idx_ff) state_ff <= S_RELEASE;
          end
          // protection bits of the page are never consulted here
          S_RELEASE: if (rx_valid) begin
            resp_idx_ff   <= 7'h00;
            resp_short_ff <= 1'b0;
            if (device_disabled) begin
              result_ff     <= RES_DISABLED;
              resp_short_ff <= 1'b1;
              state_ff      <= S_RESP;
            end else if (!param_ok) begin
              result_ff <= RES_INVALID;
              state_ff  <= S_RESP;
            end else if (fail_sticky_ff) begin
              result_ff <= RES_FAIL;
              state_ff  <= S_RESP;
            end else begin
              hash_idx_ff <= 7'h00;
              state_ff    <= S_HASH_FETCH;
            end
          end
          S_HASH_FETCH: begin
            if (hash_idx_ff >= H_PAGE0 && hash_idx_ff < H_CHAL0) begin
              page_rd_en_ff <= 1'b1;
              state_ff      <= S_HASH_WAIT;
            end else begin
              hash_valid_ff <= 1'b1;
              hash_last_ff  <= (hash_idx_ff == H_LAST);
              state_ff      <= S_HASH_PUT;
            end
          end
          S_HASH_WAIT: if (page_rd_valid) begin
            hash_valid_ff <= 1'b1;
            state_ff      <= S_HASH_PUT;
          end
          S_HASH_PUT: if (hash_ready) begin
            hash_valid_ff <= 1'b0;
            hash_last_ff  <= 1'b0;
            hash_idx_ff   <= hash_idx_ff + 7'h01;
            if (hash_idx_ff == H_LAST) begin
              sign_start_ff <= 1'b1;
              sign_cnt_ff   <= 32'h0;
              state_ff      <= S_SIGN;
            end else begin
              state_ff <= S_HASH_FETCH;
            end
          end
          S_SIGN: begin
            sign_cnt_ff <= sign_cnt_ff + 32'h1;
            if (sign_done || sign_timeout) begin
              result_ff <= (sign_done && !sign_fail) ? RES_OK : RES_FAIL;
              state_ff  <= S_RESP;
            end
          end
          S_RESP: if (push_fire) begin
            resp_idx_ff <= resp_idx_ff + 7'h01;
            if (resp_idx_ff == crc_at + 7'h01) state_ff <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // hash byte assembly
  // ****************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hash_byte_ff    <= 8'h00;
      page_rd_page_ff <= 3'h0;
      page_rd_byte_ff <= 5'h00;
    end else if (state_ff == S_HASH_FETCH) begin
      page_rd_page_ff <= param_ff[PAGE_MSB:PAGE_LSB];
      page_rd_byte_ff <= page_off[4:0];
      if (hash_idx_ff < H_PAGE0) begin
        // byte 0 of the identifier is the family code in the low bits
        hash_byte_ff <= (param_ff[IDSEL_MSB:IDSEL_LSB] == IDSEL_FF) ? HIDDEN_ID_BYTE :
                        unique_rom_identifier[{hash_idx_ff[2:0], 3'h0} +: 8];
      end else if (hash_idx_ff < H_PGNUM) begin
        hash_byte_ff <= chal_mem[chal_off[4:0]];
      end else if (hash_idx_ff == H_PGNUM) begin
        hash_byte_ff <= {5'h00, param_ff[PAGE_MSB:PAGE_LSB]};
      end else if (hash_idx_ff == H_MAKER0) begin
        hash_byte_ff <= maker_id_bytes[7:0];
      end else begin
        hash_byte_ff <= maker_id_bytes[15:8];
      end
    end else if (state_ff == S_HASH_WAIT && page_rd_valid) begin
      hash_byte_ff <= page_rd_data;
    end
  end

  // ****************************************
  // challenge and signature stores, sticky failure, status
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (state_ff == S_CHAL && rx_valid) chal_mem[chal_idx_ff[4:0]] <= rx_data;
    if (state_ff == S_SIGN && sig_byte_valid) sig_mem[sig_wr_idx_ff] <= sig_byte;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sig_wr_idx_ff <= 6'h00;
    end else if (sign_start_ff) begin
      sig_wr_idx_ff <= 6'h00;
    end else if (state_ff == S_SIGN && sig_byte_valid) begin
      sig_wr_idx_ff <= sig_wr_idx_ff + 6'h01;
    end
  end

  // only power-on reset clears a signing failure
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fail_sticky_ff <= 1'b0;
    end else if (state_ff == S_SIGN && (sign_done ? sign_fail : sign_timeout)) begin
      fail_sticky_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      key_en_ff <= 1'b0;
      busy_ff   <= 1'b0;
    end else begin
      key_en_ff <= (state_ff == S_SIGN) && !sign_done && !sign_timeout && !link_reset;
      busy_ff   <= (state_ff != S_IDLE) && !link_reset;
    end
  end

  assign page_rd_en   = page_rd_en_ff;
  assign page_rd_page = page_rd_page_ff;
  assign page_rd_byte = page_rd_byte_ff;
  assign hash_valid   = hash_valid_ff;
  assign hash_byte    = hash_byte_ff;
  assign hash_last    = hash_last_ff;
  assign sign_start   = sign_start_ff;
  assign unclonable_key_source_en = key_en_ff;
  assign busy         = busy_ff;
  assign result_code  = result_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_cmd_code_gate: assert property (
    state_ff == S_CMD && rx_valid && !link_reset && rx_data != CMD_CODE |=> state_ff == S_IDLE
  ) else $error("wrong command code not dropped");
  a_req_crc_low: assert property (
    state_ff == S_REQ_CRC && !req_crc_idx_ff |-> push_valid && push_data == ~crc_q[7:0]
  ) else $error("request crc low byte wrong");
  a_hidden_id_ff: assert property (
    state_ff == S_HASH_PUT && hash_idx_ff < H_PAGE0 && param_ff[7:5] == IDSEL_FF |-> hash_byte_ff == 8'hff
  ) else $error("anonymous identifier byte not ff");
  a_bad_page: assert property (
    state_ff == S_RELEASE && rx_valid && !link_reset && !device_disabled && param_ff[2:0] > 3'h6
    |=> result_ff == RES_INVALID && state_ff == S_RESP
  ) else $error("page above 6 not rejected");
  a_zero_sig: assert property (
    state_ff == S_RESP && resp_idx_ff >= R_SIG0 && resp_idx_ff < crc_at && result_ff != RES_OK
    |-> push_data == 8'h00
  ) else $error("signature not zeroed on error");
  a_fail_sticks: assert property (
    fail_sticky_ff |=> fail_sticky_ff
  ) else $error("signing failure flag cleared");
  a_disabled_len: assert property (
    state_ff == S_RESP && resp_idx_ff == R_LEN && result_ff == RES_DISABLED |-> push_data == 8'h01
  ) else $error("disabled response length wrong");
  a_page_num_byte: assert property (
    state_ff == S_HASH_PUT && hash_idx_ff == H_PGNUM |-> hash_byte_ff == {5'h00, param_ff[2:0]}
  ) else $error("hash page number byte wrong");
  a_maker_low: assert property (
    state_ff == S_HASH_PUT && hash_idx_ff == H_MAKER0 |-> hash_byte_ff == maker_id_bytes[7:0] && !hash_last_ff
  ) else $error("maker id low byte not first");
  a_sign_start_once: assert property (
    sign_start_ff |-> state_ff == S_SIGN ##1 !sign_start_ff
  ) else $error("sign start not a single pulse");
endmodule
`default_nettype wire

/* File: bench/sign_store_model.sv */
// bench model of the page store, hash sink and signer behind the command block
`timescale 1ns/1ps
`default_nettype none
module sign_store_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // bench control
  input  wire logic       clr,
  input  wire logic       fail_mode,
  input  wire logic       hang,
  // page store
  input  wire logic       page_rd_en,
  input  wire logic [2:0] page_rd_page,
  input  wire logic [4:0] page_rd_byte,
  output logic            page_rd_valid,
  output logic      [7:0] page_rd_data,
  // hash sink
  input  wire logic       hash_valid,
  input  wire logic [7:0] hash_byte,
  output logic            hash_ready,
  // signer
  input  wire logic       sign_start,
  output logic            sig_byte_valid,
  output logic      [7:0] sig_byte,
  output logic            sign_done,
  output logic            sign_fail
);
  // ****************************************
  // behaviour
  // ****************************************
  logic [7:0] hb_ff [75];
  logic [7:0] hcnt_ff;
  logic [7:0] sc_ff;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {page_rd_valid, hash_ready, hcnt_ff, sc_ff} <= '0;
      page_rd_data <= 8'h00;
    end else begin
      page_rd_valid <= page_rd_en;
      // stale data inverted each cycle so a sample one cycle late looks wrong
      page_rd_data <= page_rd_en ? {page_rd_page, page_rd_byte} : ~page_rd_data;
      hash_ready <= ~hash_ready;
      if (clr) hcnt_ff <= 8'h00;
      else if (hash_valid && hash_ready) begin
        hb_ff[hcnt_ff] <= hash_byte;
        hcnt_ff <= hcnt_ff + 8'h01;
      end
      sc_ff <= sign_start ? 8'h01 : (sc_ff != 8'h00 && sc_ff < 8'h48) ? sc_ff + 8'h01 : 8'h00;
    end
  end
  // bytes s then r, msb first, as an index pattern
  assign sig_byte_valid = sc_ff >= 8'h04 && sc_ff < 8'h44;
  assign sig_byte = 8'h80 ^ (sc_ff - 8'h04);
  // hang withholds done so the block must time out on its own
  assign sign_done = sc_ff == 8'h46 && !hang;
  assign sign_fail = fail_mode;
endmodule
`default_nettype wire

/* File: bench/test_page_auth_sign.sv */
// self-checking bench for the page authentication signature command
`timescale 1ns/1ps
`default_nettype none
module test_page_auth_sign;
  // ****************************************
  // stimulus and checks
  // ****************************************
  typedef struct packed {logic [7:0] prm; logic dis; logic fl; logic hsh; logic [7:0] res;} row_t;
  localparam logic [63:0] ROM   = 64'h1122334455667788; // arbitrary value
  localparam logic [15:0] MAKER = 16'hc35a;             // arbitrary value
  logic ref_clk = 0, rstn = 0, rx_valid = 0, tx_ready = 0, dis = 0, fl = 0, hang = 0;
  logic [7:0] rx_data = 8'h00;
  logic tx_valid, page_rd_en, page_rd_valid, hash_valid, hash_last, hash_ready, sign_start;
  logic key_en, sig_byte_valid, sign_done, sign_fail, busy;
  logic [7:0] tx_data, page_rd_data, hash_byte, sig_byte, result_code;
  logic [2:0] page_rd_page;
  logic [4:0] page_rd_byte;
  logic [7:0] q[$], e[$], ch[32];
  int fails, checks_done, key_n, last_at;
  row_t rows[7] = '{'{8'h03, 0, 0, 1, 8'haa}, '{8'he6, 0, 0, 1, 8'haa}, '{8'h07, 0, 0, 0, 8'h77},
                    '{8'h40, 0, 0, 0, 8'h77}, '{8'h00, 1, 0, 0, 8'h88}, '{8'h01, 0, 1, 1, 8'h22},
                    '{8'h01, 0, 0, 0, 8'h22}};
  page_auth_sign #(.SIG_TIMEOUT_CYCLES(200)) DUT (.ref_clk, .rstn, .link_reset(1'b0), .rx_valid,
    .rx_data, .tx_valid, .tx_data, .tx_ready, .unique_rom_identifier(ROM), .maker_id_bytes(MAKER),
    .device_disabled(dis), .page_rd_en, .page_rd_page, .page_rd_byte, .page_rd_valid, .page_rd_data,
    .hash_valid, .hash_byte, .hash_last, .hash_ready, .sign_start, .unclonable_key_source_en(key_en),
    .sig_byte_valid, .sig_byte, .sign_done, .sign_fail, .busy, .result_code);
  sign_store_model M (.ref_clk, .rstn, .clr(rx_valid), .fail_mode(fl), .hang, .page_rd_en, .page_rd_page,
    .page_rd_byte, .page_rd_valid, .page_rd_data, .hash_valid, .hash_byte, .hash_ready, .sign_start,
    .sig_byte_valid, .sig_byte, .sign_done, .sign_fail);
  always #4 ref_clk = ~ref_clk;
  // host stalls every other cycle
  always @(posedge ref_clk) tx_ready <= ~tx_ready;
  always @(posedge ref_clk) if (tx_valid && tx_ready) q.push_back(tx_data);
  // key must stay on while every signature byte is made; last flag marks hash byte 74
  always @(posedge ref_clk) if (sig_byte_valid && key_en) key_n++;
  always @(posedge ref_clk) if (hash_valid && hash_ready && hash_last) last_at = M.hcnt_ff;
  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return ~c;
  endfunction
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
  endtask
  task automatic await(input int n, input int lim);
    for (int k = 0; k < lim && q.size() < n; k++) @(posedge ref_clk);
    if (q.size() < n) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic run(input row_t r);
    logic [7:0] f[$];
    logic [15:0] c;
    f = {8'h66, 8'h22, 8'ha5, r.prm};
    foreach (ch[i]) ch[i] = 8'h30 + i[7:0] ^ r.prm;
    foreach (ch[i]) f.push_back(ch[i]);
    dis <= r.dis;
    fl <= r.fl;
    q.delete();
    key_n = 0;
    last_at = 0;
    send(f);
    await(2, 100);
    chk({q[1], q[0]}, crc(f));
    q.delete();
    send('{8'h5c});
    if (r.res == 8'h88) e = {8'h01, r.res};
    else begin
      e = {8'h41, r.res};
      for (int i = 0; i < 64; i++) e.push_back(r.res == 8'haa ? 8'h80 ^ i[7:0] : 8'h00);
    end
    c = crc(e);
    e.push_front(8'hff);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    await(e.size(), 3000);
    repeat (10) @(posedge ref_clk);
    chk(16'(q.size()), 16'(e.size()));
    foreach (e[i]) chk({8'h00, q[i]}, {8'h00, e[i]});
    chk(16'(key_n), r.hsh ? 16'd64 : 16'd0);
    chk(16'(last_at), r.hsh ? 16'd74 : 16'd0);
    chk({8'h00, result_code}, {8'h00, r.res});
    chk({8'h00, M.hcnt_ff}, r.hsh ? 16'd75 : 16'd0);
    if (r.hsh) begin
      chk({M.hb_ff[0], M.hb_ff[8]}, {r.prm[7] ? 8'hff : ROM[7:0], r.prm[2:0], 5'h00});
      chk({M.hb_ff[40], M.hb_ff[72]}, {ch[0], 5'h00, r.prm[2:0]});
      chk({M.hb_ff[74], M.hb_ff[73]}, MAKER);
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    send('{8'h66, 8'h22, 8'h5a});
    repeat (80) @(posedge ref_clk);
    chk(16'(q.size()), 16'h0000);
    foreach (rows[i]) run(rows[i]);
    rstn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk({5'h00, tx_valid, busy, hash_valid, result_code}, 16'h0000);
    rstn <= 1'b1;
    @(posedge ref_clk);
    run('{8'h01, 1'b0, 1'b0, 1'b1, 8'haa});
    hang <= 1'b1;
    run('{8'h01, 1'b0, 1'b0, 1'b1, 8'h22});
    report_and_stop();
  end
endmodule
`default_nettype wire
